// File: inc/pscl_consts.vh
/*
  Constants for the passive serial configuration loader.
  Assumes a 25 MHz core clock; the link clock is sampled, not used as a clock.
*/
// What this block does
// - Capture one data bit on every rising edge of the serial clock during loading.
// - Power-on delay is about 100 ms with select low, 12 ms with select high.
// - Status held low in power-on reset; user pins stay tri-stated after it.
// - Weak pull-ups on after reset and in configuration unless disable is high.
// - Stay in reset while request is low, or while status is low and request has not just risen.
// - Request high leaves reset and releases status; then ready for data.
// - After all data arrives without error, release configuration-complete.
// - Rising configuration-complete ends configuration and starts initialization.
// - Default initialization runs on internal oscillator; later serial clocks ignored.
// - User start-up clock enabled after a delay, then 4,436 cycles to user mode.
// - Init-complete goes low when its option bit loads, rises at initialization end.
// - In user mode remove weak pull-ups and run pins as the design assigns.
// - Serial clock has no maximum period; loading resumes when clocking restarts.
// - On a configuration error drive status low and reset internally.
// - Auto-restart releases status within 100 ms; otherwise host pulses request low.
`ifndef PSCL_CONSTS_VH
`define PSCL_CONSTS_VH
`define PSCL_CLK_HZ 25000000
`define PSCL_POR_LONG_MS 100
`define PSCL_POR_SHORT_MS 12
`define PSCL_POR_LONG_CYC ((`PSCL_CLK_HZ / 1000) * `PSCL_POR_LONG_MS)
`define PSCL_POR_SHORT_CYC ((`PSCL_CLK_HZ / 1000) * `PSCL_POR_SHORT_MS)
`define PSCL_ERR_TMO_MS 100
`define PSCL_ERR_TMO_CYC ((`PSCL_CLK_HZ / 1000) * `PSCL_ERR_TMO_MS)
`define PSCL_OSC_INIT_CYC 4436
`define PSCL_USR_INIT_CYC 4436
`define PSCL_UCLK_DLY_US 20
`define PSCL_UCLK_DLY_CYC ((`PSCL_CLK_HZ / 1000000) * `PSCL_UCLK_DLY_US)
`define PSCL_SCHEME_PS 3'h2
`define PSCL_BITS_W 32
`define PSCL_INITDONE_BIT 0
`endif

// File: verilog/pscl_sync_edge.v
/*
  Two-flop synchroniser with rising-edge pulse.
  Assumes the input is asynchronous to i_clk.
*/
`timescale 1ns/1ps
module pscl_sync_edge (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_async,
  output wire o_level,
  output wire o_rise
);
  reg meta_ff;
  reg sync_ff;
  reg last_ff;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else if (i_ce) begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
  assign o_level = sync_ff;
  assign o_rise = sync_ff & ~last_ff;
endmodule // pscl_sync_edge

// File: verilog/pscl_loader.v
/*
  Passive serial configuration loader, device side.
  Assumes open-drain lines have external pull-ups resolved by the bench;
  all link pins are asynchronous and sampled by I_CLK.
*/
`timescale 1ns/1ps
`include "pscl_consts.vh"
module pscl_loader #(
  parameter POR_LONG_CYC = `PSCL_POR_LONG_CYC,
  parameter POR_SHORT_CYC = `PSCL_POR_SHORT_CYC,
  parameter ERR_TMO_CYC = `PSCL_ERR_TMO_CYC,
  parameter OSC_INIT_CYC = `PSCL_OSC_INIT_CYC,
  parameter USR_INIT_CYC = `PSCL_USR_INIT_CYC,
  parameter CFG_BITS = 32'h00000400
) (
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_CE,
  input wire [2:0] I_SCHEME_SELECT_STRAPS,
  input wire I_POWER_ON_DELAY_SELECT,
  input wire I_WEAK_PULLUP_DISABLE,
  input wire I_CONFIG_REQUEST_N,
  input wire I_CONFIG_STATUS_N,
  input wire I_CONFIG_SERIAL_CLOCK,
  input wire I_SERIAL_CONFIG_DATA_IN,
  input wire I_CONFIG_COMPLETE,
  input wire I_USER_STARTUP_CLOCK,
  input wire I_USE_USER_CLOCK,
  input wire I_AUTO_RESTART,
  input wire I_CONFIG_ERROR,
  output reg O_CONFIG_STATUS_N_O,
  output reg O_CONFIG_STATUS_N_OE_N,
  output reg O_CONFIG_COMPLETE_O,
  output reg O_CONFIG_COMPLETE_OE_N,
  output reg O_INIT_DONE_O,
  output reg O_INIT_DONE_OE_N,
  output reg O_USER_IO_TRISTATE,
  output reg O_WEAK_PULLUP_EN,
  output reg O_USER_MODE,
  output reg O_BIT_VALID,
  output reg O_BIT_DATA
);
  localparam ST_POR = 3'h0;
  localparam ST_RESET = 3'h1;
  localparam ST_LOAD = 3'h2;
  localparam ST_WAITCD = 3'h3;
  localparam ST_INIT = 3'h4;
  localparam ST_USER = 3'h5;
  localparam ST_ERROR = 3'h6;

  wire req_lvl, req_rise, stat_lvl, config_serial_clock_rise, cd_lvl, cd_rise, uclk_rise;
  wire [4:0] sync_in = {I_USER_STARTUP_CLOCK, I_CONFIG_COMPLETE, I_CONFIG_SERIAL_CLOCK,
    I_CONFIG_STATUS_N, I_CONFIG_REQUEST_N};
  wire [4:0] lvl;
  wire [4:0] rise;
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sync
      pscl_sync_edge u_sync (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_async(sync_in[g]),
        .o_level(lvl[g]),
        .o_rise(rise[g])
      );
    end
  endgenerate
  assign req_lvl = lvl[0];
  assign req_rise = rise[0];
  assign stat_lvl = lvl[1];
  assign config_serial_clock_rise = rise[2];
  assign cd_lvl = lvl[3];
  assign cd_rise = rise[3];
  assign uclk_rise = rise[4];

  reg data_meta_ff, data_ff;
  reg [2:0] st_ff;
  reg [31:0] cnt_ff;
  reg [31:0] bits_ff;
  reg init_en_ff;
  reg sel_ff;
  reg ps_ok_ff;
  reg por_ld_ff;
  reg [2:0] nxt_st;
  reg [31:0] nxt_cnt;

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      data_meta_ff <= 1'b0;
      data_ff <= 1'b0;
    end else if (I_CE) begin
      data_meta_ff <= I_SERIAL_CONFIG_DATA_IN;
      data_ff <= data_meta_ff;
    end
  end

  always @* begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      ST_POR: begin
        if (!por_ld_ff) begin
          nxt_cnt = I_POWER_ON_DELAY_SELECT ? POR_SHORT_CYC : POR_LONG_CYC;
        end else if (cnt_ff == 32'h00000000) begin
          nxt_st = ST_RESET;
        end else begin
          nxt_cnt = cnt_ff - 32'h00000001;
        end
      end
      ST_RESET: begin
        if (req_rise || (req_lvl && stat_lvl)) begin
          nxt_st = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (I_CONFIG_ERROR || !ps_ok_ff) begin
          nxt_st = ST_ERROR;
          nxt_cnt = ERR_TMO_CYC;
        end else if (bits_ff >= CFG_BITS) begin
          nxt_st = ST_WAITCD;
        end
      end
      ST_WAITCD: begin
        if (cd_rise || cd_lvl) begin
          nxt_st = ST_INIT;
          nxt_cnt = sel_ff ? (USR_INIT_CYC + `PSCL_UCLK_DLY_CYC) : OSC_INIT_CYC;
        end
      end
      ST_INIT: begin
        if (cnt_ff == 32'h00000000) begin
          nxt_st = ST_USER;
        end else if (!sel_ff || cnt_ff > USR_INIT_CYC || uclk_rise) begin
          nxt_cnt = cnt_ff - 32'h00000001;
        end
      end
      ST_USER: nxt_st = ST_USER;
      ST_ERROR: begin
        if (I_AUTO_RESTART && cnt_ff != 32'h00000000) begin
          nxt_cnt = cnt_ff - 32'h00000001;
        end else if (I_AUTO_RESTART) begin
          nxt_st = ST_RESET;
        end
      end
      default: nxt_st = ST_RESET;
    endcase
    if (st_ff != ST_POR && !req_lvl) begin
      nxt_st = ST_RESET;
    end
  end

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_ff <= ST_POR;
      cnt_ff <= 32'h00000000;
      bits_ff <= 32'h00000000;
      init_en_ff <= 1'b0;
      sel_ff <= 1'b0;
      ps_ok_ff <= 1'b0;
      por_ld_ff <= 1'b0;
      O_CONFIG_STATUS_N_O <= 1'b0;
      O_CONFIG_STATUS_N_OE_N <= 1'b0;
      O_CONFIG_COMPLETE_O <= 1'b0;
      O_CONFIG_COMPLETE_OE_N <= 1'b0;
      O_INIT_DONE_O <= 1'b0;
      O_INIT_DONE_OE_N <= 1'b1;
      O_USER_IO_TRISTATE <= 1'b1;
      O_WEAK_PULLUP_EN <= 1'b0;
      O_USER_MODE <= 1'b0;
      O_BIT_VALID <= 1'b0;
      O_BIT_DATA <= 1'b0;
    end else if (I_CE) begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      O_BIT_VALID <= 1'b0;
      por_ld_ff <= 1'b1;
      if (st_ff == ST_RESET) begin
        bits_ff <= 32'h00000000;
        init_en_ff <= 1'b0;
        sel_ff <= I_USE_USER_CLOCK;
        ps_ok_ff <= (I_SCHEME_SELECT_STRAPS == `PSCL_SCHEME_PS);
      end
      if (st_ff == ST_LOAD && nxt_st == ST_LOAD && config_serial_clock_rise) begin
        bits_ff <= bits_ff + 32'h00000001;
        O_BIT_VALID <= 1'b1;
        O_BIT_DATA <= data_ff;
        if (bits_ff == `PSCL_INITDONE_BIT) begin
          init_en_ff <= data_ff;
        end
      end
      O_CONFIG_STATUS_N_OE_N <= !(nxt_st == ST_POR || nxt_st == ST_ERROR
        || (nxt_st == ST_RESET && !req_lvl));
      O_CONFIG_COMPLETE_OE_N <= !(nxt_st == ST_POR || nxt_st == ST_RESET || nxt_st == ST_LOAD
        || nxt_st == ST_ERROR);
      O_INIT_DONE_OE_N <= !(init_en_ff && (nxt_st == ST_LOAD || nxt_st == ST_WAITCD
        || nxt_st == ST_INIT));
      O_USER_IO_TRISTATE <= (nxt_st != ST_USER);
      O_WEAK_PULLUP_EN <= (nxt_st != ST_USER) && (nxt_st != ST_POR) && !I_WEAK_PULLUP_DISABLE;
      O_USER_MODE <= (nxt_st == ST_USER);
    end
  end
endmodule // pscl_loader

// File: tb/pscl_host.sv
/* Host model: shifts one 16-bit word LSB first.
   Assumes the resolved status line as input. */
`timescale 1ns/1ps
module pscl_host (
  input wire i_go,
  input wire [15:0] i_word,
  input wire i_pause,
  input wire i_status_n,
  output logic o_sclk,
  output logic o_sdata
);
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
  end
  always @(posedge i_go) begin
    #7; // Stay clear of core clock edges
    for (int i = 0; i < 16; i++) begin
      if (!i_status_n) begin
        wait (i_status_n);
        #7;
      end
      o_sdata = i_word[i];
      #160 o_sclk = 1'b1;
      #160 o_sclk = 1'b0;
      if (i_pause && i == 7) #5000;
    end
    o_sdata = 1'b0;
  end
endmodule // pscl_host

// File: tb/pscl_loader_chk.sv
/* Port checker for the loader.
   Assumes bind onto pscl_loader. */
`timescale 1ns/1ps
module pscl_loader_chk #(
  parameter CFG_BITS = 16
) (
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_CONFIG_REQUEST_N,
  input wire I_CONFIG_COMPLETE,
  input wire I_AUTO_RESTART,
  input wire I_CONFIG_ERROR,
  input wire O_CONFIG_STATUS_N_OE_N,
  input wire O_CONFIG_COMPLETE_OE_N,
  input wire O_INIT_DONE_OE_N,
  input wire O_USER_IO_TRISTATE,
  input wire O_WEAK_PULLUP_EN,
  input wire O_USER_MODE,
  input wire O_BIT_VALID
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  reg [31:0] bit_cnt_ff;
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) bit_cnt_ff <= 32'h0;
    else if (!O_CONFIG_STATUS_N_OE_N) bit_cnt_ff <= 32'h0;
    else bit_cnt_ff <= bit_cnt_ff + O_BIT_VALID;
  end
  property p_por; $rose(I_RST_N) |-> !O_CONFIG_STATUS_N_OE_N && O_USER_IO_TRISTATE; endproperty
  a_por: assert property (p_por) else $error("status not held");
  property p_req; !I_CONFIG_REQUEST_N [*8] |-> !O_CONFIG_STATUS_N_OE_N && !O_USER_MODE; endproperty
  a_req: assert property (p_req) else $error("reset stage left");
  property p_rel; $rose(O_CONFIG_STATUS_N_OE_N) |-> $past(I_CONFIG_REQUEST_N, 3); endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_bit; O_BIT_VALID |-> O_CONFIG_STATUS_N_OE_N ##1 !O_BIT_VALID; endproperty
  a_bit: assert property (p_bit) else $error("bad bit pulse");
  property p_done; $rose(O_CONFIG_COMPLETE_OE_N) |-> ##1 bit_cnt_ff == CFG_BITS; endproperty
  a_done: assert property (p_done) else $error("wrong bit count");
  property p_user;
    $rose(O_USER_MODE) |-> !O_USER_IO_TRISTATE && !O_WEAK_PULLUP_EN && O_INIT_DONE_OE_N
      && I_CONFIG_COMPLETE;
  endproperty
  a_user: assert property (p_user) else $error("bad user entry");
  property p_err;
    I_CONFIG_ERROR && O_CONFIG_STATUS_N_OE_N && !O_CONFIG_COMPLETE_OE_N
      |-> ##[1:4] !O_CONFIG_STATUS_N_OE_N;
  endproperty
  a_err: assert property (p_err) else $error("error not flagged");
  property p_rst;
    $fell(O_CONFIG_STATUS_N_OE_N) && I_AUTO_RESTART && I_CONFIG_REQUEST_N
      |-> ##[1:70] O_CONFIG_STATUS_N_OE_N;
  endproperty
  a_rst: assert property (p_rst) else $error("no restart");
  c_user: cover property ($rose(O_USER_MODE));
  c_bit: cover property (O_BIT_VALID);
  c_rst: cover property ($fell(O_CONFIG_STATUS_N_OE_N) && I_AUTO_RESTART);
endmodule // pscl_loader_chk
bind pscl_loader pscl_loader_chk #(.CFG_BITS(CFG_BITS)) u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_CONFIG_REQUEST_N(I_CONFIG_REQUEST_N), .I_CONFIG_COMPLETE(I_CONFIG_COMPLETE),
  .I_AUTO_RESTART(I_AUTO_RESTART), .I_CONFIG_ERROR(I_CONFIG_ERROR),
  .O_CONFIG_STATUS_N_OE_N(O_CONFIG_STATUS_N_OE_N), .O_CONFIG_COMPLETE_OE_N(O_CONFIG_COMPLETE_OE_N),
  .O_INIT_DONE_OE_N(O_INIT_DONE_OE_N), .O_USER_IO_TRISTATE(O_USER_IO_TRISTATE),
  .O_WEAK_PULLUP_EN(O_WEAK_PULLUP_EN), .O_USER_MODE(O_USER_MODE), .O_BIT_VALID(O_BIT_VALID));

// File: tb/pscl_loader_test.sv
/* Loader bench with host model.
   Assumes open-drain lines resolved here with pull-ups. */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t mismatch", $time); end end
`define WT(c, n) begin k = 0; while (!(c) && k < n) begin @(posedge clk); k++; end \
  num_checks++; if (!(c)) begin error_cnt++; $display("BAD %0t timeout", $time); end_sim; end end
module pscl_loader_test;
  logic clk, rst_n, sel, dis, uuse, uclk, req_n, auto, err, go, pause, ce;
  logic [2:0] mode;
  logic [15:0] word, got;
  wire sclk, sdata, st_oe_n, cd_oe_n, id_oe_n, umode, tri_s, pu, bv, bd, st_o, cd_o, id_o;
  wire st_n = st_oe_n ? 1'b1 : st_o;
  wire cd_n = cd_oe_n ? 1'b1 : cd_o;
  wire id_n = id_oe_n ? 1'b1 : id_o;
  int error_cnt, num_checks, k, nb;
  pscl_host i_host (.i_go(go), .i_word(word), .i_pause(pause), .i_status_n(st_n),
    .o_sclk(sclk), .o_sdata(sdata));
  pscl_loader #(.POR_LONG_CYC(32'h28), .POR_SHORT_CYC(32'h14), .ERR_TMO_CYC(32'h32),
    .USR_INIT_CYC(32'h14), .CFG_BITS(32'h10)) i_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_SCHEME_SELECT_STRAPS(mode),
    .I_POWER_ON_DELAY_SELECT(sel), .I_WEAK_PULLUP_DISABLE(dis), .I_CONFIG_REQUEST_N(req_n),
    .I_CONFIG_STATUS_N(st_n), .I_CONFIG_SERIAL_CLOCK(sclk), .I_SERIAL_CONFIG_DATA_IN(sdata),
    .I_CONFIG_COMPLETE(cd_n), .I_USER_STARTUP_CLOCK(uclk), .I_USE_USER_CLOCK(uuse),
    .I_AUTO_RESTART(auto), .I_CONFIG_ERROR(err), .O_CONFIG_STATUS_N_O(st_o),
    .O_CONFIG_STATUS_N_OE_N(st_oe_n), .O_CONFIG_COMPLETE_O(cd_o), .O_CONFIG_COMPLETE_OE_N(cd_oe_n),
    .O_INIT_DONE_O(id_o), .O_INIT_DONE_OE_N(id_oe_n), .O_USER_IO_TRISTATE(tri_s),
    .O_WEAK_PULLUP_EN(pu), .O_USER_MODE(umode), .O_BIT_VALID(bv), .O_BIT_DATA(bd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always #50 uclk = ~uclk;
  always @(posedge clk) begin
    if (bv) begin
      got <= {bd, got[15:1]};
      nb <= nb + 1;
    end
  end
  task end_sim;
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task kick;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task do_reset(input logic s, input logic d, input logic u);
    rst_n <= 1'b0;
    sel <= s;
    dis <= d;
    uuse <= u;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (s ? 18 : 38) @(posedge clk);
    `CHK(st_n, 1'b0)
    `WT(st_n, 12)
  endtask
  task load(input logic [15:0] w, input logic p);
    nb = 0;
    word <= w;
    pause <= p;
    kick;
    `WT(cd_n, 1000)
    `CHK(got, w)
    `CHK(nb, 16)
    `CHK(id_n, ~w[0])
    `WT(umode, 5000)
    `CHK({tri_s, pu, id_n}, 3'h1)
  endtask
  task s_short;
    do_reset(1'b1, 1'b0, 1'b0);
    `CHK(pu, 1'b1)
    load(16'hA5C3, 1'b0);
    nb = 0;
    kick;
    repeat (150) @(posedge clk);
    `CHK({nb == 0, umode}, 2'h3)
  endtask
  task s_err;
    mode <= 3'h3;
    do_reset(1'b1, 1'b0, 1'b0);
    `WT(!st_n, 6)
    mode <= 3'h2;
    req_n <= 1'b0;
    repeat (8) @(posedge clk);
    req_n <= 1'b1;
    `WT(st_n, 12)
    auto <= 1'b1;
    nb = 0;
    kick;
    `WT(nb > 4, 200)
    err <= 1'b1;
    @(posedge clk);
    err <= 1'b0;
    `WT(!st_n, 6)
    `WT(st_n, 80)
    repeat (4) @(posedge clk);
    auto <= 1'b0;
    err <= 1'b1;
    @(posedge clk);
    err <= 1'b0;
    `WT(!st_n, 6)
    repeat (80) @(posedge clk);
    `CHK(st_n, 1'b0)
    req_n <= 1'b0;
    repeat (60) @(posedge clk);
    `CHK({st_n, cd_n}, 2'h0)
    ce <= 1'b0;
    req_n <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(st_n, 1'b0)
    ce <= 1'b1;
    `WT(st_n, 12)
  endtask
  initial begin
    {rst_n, sel, dis, uuse, uclk, auto, err, go, pause} = 9'h0;
    req_n = 1'b1;
    ce = 1'b1;
    mode = 3'h2;
    word = 16'h0;
    @(posedge clk);
    s_short;
    do_reset(1'b0, 1'b1, 1'b1);
    `CHK(pu, 1'b0)
    load(16'h3C96, 1'b1);
    s_err;
    end_sim;
  end
endmodule // pscl_loader_test
